// file: omcs_pkg.sv
// omcs_pkg: constants shared by the optical module control/status logic.
// assumes: byte-wide register port, single 200 MHz clock domain.
package omcs_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OMCS_STATUS_CONTROL_OFS = 8'h6E;
    localparam logic [7:0] OMCS_EXTENDED_CONTROL_OFS = 8'h76;

    // ------------------------------------------------------------
    // status_control_byte field positions
    // ------------------------------------------------------------
    localparam int OMCS_SC_TX_OFF_STATE_BIT = 7;
    localparam int OMCS_SC_SOFT_TX_OFF_BIT = 6;
    localparam int OMCS_SC_TX_RATE_STATE_BIT = 5;
    localparam int OMCS_SC_RX_RATE_STATE_BIT = 4;
    localparam int OMCS_SC_SOFT_RX_RATE_BIT = 3;
    localparam int OMCS_SC_FAULT_BIT = 2;
    localparam int OMCS_SC_SIGNAL_LOST_BIT = 1;

    // ------------------------------------------------------------
    // extended_control_byte field positions
    // ------------------------------------------------------------
    localparam int OMCS_EC_SOFT_TX_RATE_BIT = 3;

    // ------------------------------------------------------------
    // reset values and answer to unmapped reads
    // ------------------------------------------------------------
    localparam logic OMCS_SOFT_BIT_RST = 1'h0;
    localparam logic [7:0] OMCS_EXTENDED_CONTROL_RST = 8'h00;
    localparam logic [7:0] OMCS_UNMAPPED_RDATA = 8'h00;

    // ------------------------------------------------------------
    // status_control_byte bits that software may write
    // ------------------------------------------------------------
    localparam logic [7:0] OMCS_SC_WRITABLE_MASK = 8'h48;

endpackage : omcs_pkg

// file: omcs_fault_latch.sv
// omcs_fault_latch: sticky laser fault flag.
// assumes: all inputs synchronous to i_clock.
`timescale 1ns/100ps
`default_nettype none

module omcs_fault_latch
    import omcs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_set,
    input wire logic i_clear_pin,
    output logic o_fault
);

    typedef struct packed {
        logic fault;
        logic pin_prev;
    } omcs_latch_state_t;

    omcs_latch_state_t state_r;
    omcs_latch_state_t state_nxt;

    // ------------------------------------------------------------
    // latch: cleared on a rising edge of the disable pin
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.pin_prev = i_clear_pin;
        // a fault in the clearing cycle wins, so no event is lost
        if (i_set) begin
            state_nxt.fault = 1'h1;
        end else if (i_clear_pin && !state_r.pin_prev) begin
            state_nxt.fault = 1'h0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_fault = state_r.fault;

endmodule : omcs_fault_latch

`default_nettype wire

// file: omcs_ctrl_status.sv
// omcs_ctrl_status: laser fault, eye safety, rate select, loss of signal
// and the two host-visible control/status bytes.
// assumes: pins synchronous to i_clock; the serial engine outside turns
// host transfers into single-cycle byte reads and writes on the reg port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - on a laser fault, switch laser off and raise the fault output
// - fault output stays latched until disable pin toggles or power cycles
// - fault condition mirrored in status byte bit 2
// - eye-safety monitor disables transmitter whenever power is unsafe
// - transmit rate select high selects 8.5 Gb/s optical power
// - transmit rate is pin OR soft bit 3 of extended byte
// - transmit rate state reported in status byte bit 5
// - receive rate select high optimises receiver chain for 8.5 Gb/s
// - receive rate is pin OR soft bit 3 of status byte
// - receive rate state reported in status byte bit 4
// - signal-lost output low for adequate input, high when unusable
// - signal-lost condition mirrored in status byte bit 1
// - transmit-off high shuts the optical output, low permits operation
// - transmit disable is pin OR soft bit 6 of status byte
// - transmit disable state reported in status byte bit 7
module omcs_ctrl_status
    import omcs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_transmit_off_in,
    input wire logic i_tx_rate_select,
    input wire logic i_rx_rate_select,
    input wire logic i_laser_fault_event,
    input wire logic i_tx_power_unsafe,
    input wire logic i_rx_input_unusable,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_laser_on,
    output logic o_laser_fault_out,
    output logic o_laser_fault_oe,
    output logic o_laser_fault,
    output logic o_tx_rate_high,
    output logic o_rx_rate_high,
    output logic o_rx_signal_lost
);

    typedef struct packed {
        logic laser_on;
        logic soft_tx_off;
        logic soft_rx_rate;
        logic [7:0] ext_ctrl;
        logic tx_rate;
        logic rx_rate;
        logic signal_lost;
        logic [7:0] rdata;
        logic rvalid;
    } omcs_state_t;

    omcs_state_t state_r;
    omcs_state_t state_nxt;
    logic fault;
    logic fault_trip;
    logic tx_off_eff;
    logic [7:0] status_byte;

    // ------------------------------------------------------------
    // fault latch
    // ------------------------------------------------------------
    // an eye-safety trip is a fault too, so it also needs a disable toggle
    assign fault_trip = i_laser_fault_event | i_tx_power_unsafe;

    omcs_fault_latch u_fault_latch (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_set(fault_trip),
        .i_clear_pin(i_transmit_off_in),
        .o_fault(fault)
    );

    // ------------------------------------------------------------
    // status byte assembly
    // ------------------------------------------------------------
    assign tx_off_eff = i_transmit_off_in | state_r.soft_tx_off;

    always_comb begin
        status_byte = 8'h00;
        status_byte[OMCS_SC_TX_OFF_STATE_BIT] = i_transmit_off_in;
        status_byte[OMCS_SC_SOFT_TX_OFF_BIT] = state_r.soft_tx_off;
        status_byte[OMCS_SC_TX_RATE_STATE_BIT] = i_tx_rate_select;
        status_byte[OMCS_SC_RX_RATE_STATE_BIT] = i_rx_rate_select;
        status_byte[OMCS_SC_SOFT_RX_RATE_BIT] = state_r.soft_rx_rate;
        status_byte[OMCS_SC_FAULT_BIT] = fault;
        status_byte[OMCS_SC_SIGNAL_LOST_BIT] = i_rx_input_unusable;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = 1'h0;
        // laser runs only with no disable, no latched fault, no trip now
        state_nxt.laser_on = !(tx_off_eff || fault
            || fault_trip);
        state_nxt.tx_rate = i_tx_rate_select
            | state_r.ext_ctrl[OMCS_EC_SOFT_TX_RATE_BIT];
        state_nxt.rx_rate = i_rx_rate_select
            | state_r.soft_rx_rate;
        state_nxt.signal_lost = i_rx_input_unusable;
        if (i_reg_wr) begin
            // in the status byte only the soft bits take a write and mirrored bits ignore it; the extended byte takes all eight
            if (i_reg_addr == OMCS_STATUS_CONTROL_OFS) begin
                state_nxt.soft_tx_off
                    = i_reg_wdata[OMCS_SC_SOFT_TX_OFF_BIT];
                state_nxt.soft_rx_rate = i_reg_wdata[OMCS_SC_SOFT_RX_RATE_BIT];
            end else if (i_reg_addr == OMCS_EXTENDED_CONTROL_OFS) begin
                state_nxt.ext_ctrl = i_reg_wdata;
            end
        end
        if (i_reg_rd) begin
            state_nxt.rvalid = 1'h1;
            if (i_reg_addr == OMCS_STATUS_CONTROL_OFS) begin
                state_nxt.rdata = status_byte;
            end else if (i_reg_addr == OMCS_EXTENDED_CONTROL_OFS) begin
                state_nxt.rdata = state_r.ext_ctrl;
            end else begin
                state_nxt.rdata = OMCS_UNMAPPED_RDATA;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_r <= '0;
            state_r.soft_tx_off <= OMCS_SOFT_BIT_RST;
            state_r.soft_rx_rate <= OMCS_SOFT_BIT_RST;
            state_r.ext_ctrl <= OMCS_EXTENDED_CONTROL_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_rdata = state_r.rdata;
    assign o_reg_rvalid = state_r.rvalid;
    assign o_laser_on = state_r.laser_on;
    assign o_tx_rate_high = state_r.tx_rate;
    assign o_rx_rate_high = state_r.rx_rate;
    assign o_rx_signal_lost = state_r.signal_lost;
    assign o_laser_fault = fault;
    // open drain: pull low while healthy, release so the pull-up shows high
    assign o_laser_fault_out = 1'h0;
    assign o_laser_fault_oe = !fault;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_fault_raises;
        @(posedge i_clock) disable iff (i_rst)
        i_laser_fault_event |=> (o_laser_fault && !o_laser_on
            && !o_laser_fault_oe);
    endproperty
    a_fault_raises: assert property (p_fault_raises)
        else $error("laser fault did not raise fault and stop laser");

    property p_fault_holds;
        @(posedge i_clock) disable iff (i_rst)
        (o_laser_fault && !(i_transmit_off_in && !$past(i_transmit_off_in)))
            |=> o_laser_fault;
    endproperty
    a_fault_holds: assert property (p_fault_holds)
        else $error("fault cleared without disable toggle");

    property p_fault_clears;
        @(posedge i_clock) disable iff (i_rst)
        ($rose(i_transmit_off_in) && !fault_trip) |=> !o_laser_fault;
    endproperty
    a_fault_clears: assert property (p_fault_clears)
        else $error("disable toggle did not clear fault");

    property p_status_read;
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == OMCS_STATUS_CONTROL_OFS) |=>
            (o_reg_rvalid
            && o_reg_rdata[OMCS_SC_FAULT_BIT] == $past(fault)
            && o_reg_rdata[OMCS_SC_SIGNAL_LOST_BIT]
                == $past(i_rx_input_unusable)
            && o_reg_rdata[OMCS_SC_TX_OFF_STATE_BIT]
                == $past(i_transmit_off_in)
            && o_reg_rdata[OMCS_SC_TX_RATE_STATE_BIT]
                == $past(i_tx_rate_select)
            && o_reg_rdata[OMCS_SC_RX_RATE_STATE_BIT]
                == $past(i_rx_rate_select));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status byte does not mirror pin and fault state");

    property p_off_state;
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == OMCS_STATUS_CONTROL_OFS) |=>
            (o_reg_rdata[OMCS_SC_TX_OFF_STATE_BIT] == $past(i_transmit_off_in)
            && o_reg_rdata[OMCS_SC_SOFT_TX_OFF_BIT]
                == $past(state_r.soft_tx_off));
    endproperty
    a_off_state: assert property (p_off_state)
        else $error("status byte disable bits do not match disable state");

    property p_unsafe_off;
        @(posedge i_clock) disable iff (i_rst)
        i_tx_power_unsafe |=> !o_laser_on;
    endproperty
    a_unsafe_off: assert property (p_unsafe_off)
        else $error("laser left on under unsafe power");

    property p_tx_rate;
        @(posedge i_clock) disable iff (i_rst)
        i_tx_rate_select |=> o_tx_rate_high;
    endproperty
    a_tx_rate: assert property (p_tx_rate)
        else $error("tx rate pin high but rate output low");

    property p_soft_tx_rate;
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == OMCS_EXTENDED_CONTROL_OFS
            && i_reg_wdata[OMCS_EC_SOFT_TX_RATE_BIT]) ##1 !i_reg_wr
            |=> o_tx_rate_high;
    endproperty
    a_soft_tx_rate: assert property (p_soft_tx_rate)
        else $error("soft tx rate bit ignored");

    property p_rx_rate;
        @(posedge i_clock) disable iff (i_rst)
        ##1 (o_rx_rate_high
            == $past(i_rx_rate_select | state_r.soft_rx_rate));
    endproperty
    a_rx_rate: assert property (p_rx_rate)
        else $error("rx rate is not pin or soft bit");

    property p_signal_lost;
        @(posedge i_clock) disable iff (i_rst)
        ##1 (o_rx_signal_lost == $past(i_rx_input_unusable));
    endproperty
    a_signal_lost: assert property (p_signal_lost)
        else $error("signal-lost output wrong");

    property p_tx_off;
        @(posedge i_clock) disable iff (i_rst)
        (i_transmit_off_in || state_r.soft_tx_off) |=> !o_laser_on;
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("laser on while transmit disabled");

    property p_ro_bits;
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == OMCS_STATUS_CONTROL_OFS) |=>
            (fault == $past(fault) || $past(fault_trip)
            || $past(i_transmit_off_in));
    endproperty
    a_ro_bits: assert property (p_ro_bits)
        else $error("write to status byte changed the fault flag");

    c_fault_cleared: cover property (@(posedge i_clock) disable iff (i_rst)
        o_laser_fault ##[1:20] !o_laser_fault);
    c_soft_off: cover property (@(posedge i_clock) disable iff (i_rst)
        state_r.soft_tx_off && !i_transmit_off_in);
    c_rx_soft_rate: cover property (@(posedge i_clock) disable iff (i_rst)
        o_rx_rate_high && !i_rx_rate_select);
    c_unmapped_read: cover property (@(posedge i_clock) disable iff (i_rst)
        i_reg_rd && i_reg_addr != OMCS_STATUS_CONTROL_OFS
        && i_reg_addr != OMCS_EXTENDED_CONTROL_OFS);

endmodule : omcs_ctrl_status

`default_nettype wire

// file: omcs_host_model.sv
// omcs_host_model: host board side of the laser fault line.
// assumes: the device splits the open-drain pin into data and enable.
`timescale 1ns/100ps
`default_nettype none

module omcs_host_model (
    input wire logic i_fault_oe,
    input wire logic i_fault_data,
    output logic o_fault_pin
);
    // ------------------------------------------------------------
    // board pull-up
    // ------------------------------------------------------------
    // a released line floats up to the pull-up, so it reads high
    assign o_fault_pin = i_fault_oe ? i_fault_data : 1'b1;
endmodule : omcs_host_model

`default_nettype wire

// file: omcs_ctrl_status_tb.sv
// omcs_ctrl_status_tb: self-checking bench for the control/status block.
// assumes: byte strobe register port, one 200 MHz clock, host pull-up model.
`timescale 1ns/100ps
`default_nettype none

module omcs_ctrl_status_tb;
    import omcs_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic tx_off = 1'b0;
    logic tx_rs = 1'b0;
    logic rx_rs = 1'b0;
    logic fault_ev = 1'b0;
    logic unsafe = 1'b0;
    logic los_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic rvalid, las_en, f_data, f_oe, fault, tx_hi, rx_hi, los;
    wire logic fault_pin;
    int checks = 0;
    int error_cnt = 0;
    int cyc = 0;

    always #2.5 clock = ~clock;

    omcs_ctrl_status dut_u (
        .i_clock(clock), .i_rst(rst), .i_transmit_off_in(tx_off),
        .i_tx_rate_select(tx_rs), .i_rx_rate_select(rx_rs),
        .i_laser_fault_event(fault_ev), .i_tx_power_unsafe(unsafe),
        .i_rx_input_unusable(los_in), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_laser_on(las_en),
        .o_laser_fault_out(f_data), .o_laser_fault_oe(f_oe),
        .o_laser_fault(fault), .o_tx_rate_high(tx_hi),
        .o_rx_rate_high(rx_hi), .o_rx_signal_lost(los)
    );

    omcs_host_model host_u (
        .i_fault_oe(f_oe), .i_fault_data(f_data), .o_fault_pin(fault_pin)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // outputs are registered: look one edge after the inputs were taken
    task automatic settle();
        @(posedge clock);
        #1;
    endtask : settle

    task automatic chk_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk_bit("rvalid", 1'b1, rvalid);
        chk_byte("rdata", e, rdata);
        settle();
        chk_bit("rvalid_end", 1'b0, rvalid);
    endtask : reg_rd

    // hang guard, far above the length of the sequence below
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        settle();
        chk_bit("laser_en", 1'b1, las_en);
        chk_bit("fault_pin", 1'b0, fault_pin);
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h00);
        reg_rd(OMCS_EXTENDED_CONTROL_OFS, OMCS_EXTENDED_CONTROL_RST);
        reg_rd(8'h6F, OMCS_UNMAPPED_RDATA);
        // transmit rate from the pin, then from the soft bit alone
        @(posedge clock);
        tx_rs <= 1'b1;
        settle();
        chk_bit("tx_rate", 1'b1, tx_hi);
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h20);
        @(posedge clock);
        tx_rs <= 1'b0;
        reg_wr(OMCS_EXTENDED_CONTROL_OFS, 8'h08);
        settle();
        chk_bit("tx_rate_soft", 1'b1, tx_hi);
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h00);
        reg_wr(OMCS_EXTENDED_CONTROL_OFS, 8'hF7);
        settle();
        chk_bit("tx_rate_other", 1'b0, tx_hi);
        reg_rd(OMCS_EXTENDED_CONTROL_OFS, 8'hF7);
        // receive rate from the pin, then from the soft bit alone
        @(posedge clock);
        rx_rs <= 1'b1;
        settle();
        chk_bit("rx_rate", 1'b1, rx_hi);
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h10);
        @(posedge clock);
        rx_rs <= 1'b0;
        reg_wr(OMCS_STATUS_CONTROL_OFS, 8'h08);
        settle();
        chk_bit("rx_rate_soft", 1'b1, rx_hi);
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h08);
        // all ones: only the two soft bits may stick
        reg_wr(OMCS_STATUS_CONTROL_OFS, 8'hFF);
        settle();
        chk_bit("soft_off", 1'b0, las_en);
        reg_rd(OMCS_STATUS_CONTROL_OFS, OMCS_SC_WRITABLE_MASK);
        reg_wr(OMCS_STATUS_CONTROL_OFS, 8'h00);
        settle();
        chk_bit("soft_off_clr", 1'b1, las_en);
        chk_bit("rx_rate_clr", 1'b0, rx_hi);
        // a write to an unmapped byte lands nowhere
        reg_wr(8'h6F, 8'hFF);
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h00);
        reg_rd(OMCS_EXTENDED_CONTROL_OFS, 8'hF7);
        @(posedge clock);
        tx_off <= 1'b1;
        settle();
        chk_bit("pin_off", 1'b0, las_en);
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h80);
        @(posedge clock);
        tx_off <= 1'b0;
        los_in <= 1'b1;
        settle();
        chk_bit("sig_lost", 1'b1, los);
        chk_bit("pin_free", 1'b1, las_en);
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h02);
        @(posedge clock);
        los_in <= 1'b0;
        settle();
        chk_bit("sig_ok", 1'b0, los);
        // single-cycle fault event must stay latched
        @(posedge clock);
        fault_ev <= 1'b1;
        @(posedge clock);
        fault_ev <= 1'b0;
        #1;
        chk_bit("fault", 1'b1, fault);
        chk_bit("fault_pin", 1'b1, fault_pin);
        chk_bit("laser_fault", 1'b0, las_en);
        repeat (5) settle();
        reg_rd(OMCS_STATUS_CONTROL_OFS, 8'h04);
        // the soft disable bit does not clear the latch
        reg_wr(OMCS_STATUS_CONTROL_OFS, 8'h40);
        reg_wr(OMCS_STATUS_CONTROL_OFS, 8'h00);
        settle();
        chk_bit("fault_held", 1'b1, fault_pin);
        @(posedge clock);
        tx_off <= 1'b1;
        settle();
        chk_bit("fault_clr", 1'b0, fault);
        chk_bit("laser_held", 1'b0, las_en);
        @(posedge clock);
        tx_off <= 1'b0;
        settle();
        settle();
        chk_bit("laser_back", 1'b1, las_en);
        chk_bit("pin_low", 1'b0, fault_pin);
        // eye-safety trip
        @(posedge clock);
        unsafe <= 1'b1;
        settle();
        chk_bit("eye_trip", 1'b0, las_en);
        @(posedge clock);
        unsafe <= 1'b0;
        settle();
        settle();
        chk_bit("eye_held", 1'b0, las_en);
        @(posedge clock);
        tx_off <= 1'b1;
        @(posedge clock);
        tx_off <= 1'b0;
        settle();
        settle();
        chk_bit("eye_clr", 1'b1, las_en);
        // a fault in the clearing cycle wins over the toggle
        @(posedge clock);
        fault_ev <= 1'b1;
        @(posedge clock);
        tx_off <= 1'b1;
        @(posedge clock);
        fault_ev <= 1'b0;
        tx_off <= 1'b0;
        #1;
        chk_bit("fault_set_wins", 1'b1, fault);
        @(posedge clock);
        tx_off <= 1'b1;
        @(posedge clock);
        tx_off <= 1'b0;
        settle();
        chk_bit("fault_retoggle", 1'b0, fault);
        // mid-run reset clears the soft bits and the extended byte
        reg_wr(OMCS_EXTENDED_CONTROL_OFS, 8'h5A);
        settle();
        chk_bit("tx_rate_pre", 1'b1, tx_hi);
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        settle();
        chk_bit("laser_rst", 1'b1, las_en);
        chk_bit("tx_rate_rst", 1'b0, tx_hi);
        reg_rd(OMCS_EXTENDED_CONTROL_OFS, OMCS_EXTENDED_CONTROL_RST);
        stop_test();
    end
endmodule : omcs_ctrl_status_tb

`default_nettype wire
